// ==== hdl/status_group_pkg.sv ====
package status_group_pkg;

    localparam int          REG_W             = 16;
    localparam logic [15:0] WRITE_LIMIT_MASK  = 16'h7fff;   // values 0..32767 only
    // condition bit positions
    localparam int          DEV_SENSOR_BIT    = 1;
    localparam int          DEV_ERROR_BIT     = 3;
    localparam int          PQ_OVERLOAD_BIT   = 1;
    localparam int          PQ_ZERO_REQ_BIT   = 3;
    localparam int          PQ_INVALID_BIT    = 5;
    // reset values
    localparam logic [15:0] RST_ENABLE        = 16'h0000;
    localparam logic [15:0] RST_EVENT         = 16'h0000;
    localparam logic [15:0] RST_RISE_FILTER   = 16'h7fff;
    localparam logic [15:0] RST_FALL_FILTER   = 16'h0000;

    // register selectors of the command port
    typedef enum logic [2:0] {
        SEL_CONDITION = 3'h0,
        SEL_ENABLE    = 3'h1,
        SEL_EVENT     = 3'h2,
        SEL_FALL      = 3'h3,
        SEL_RISE      = 3'h4
    } reg_sel_t;

    // one host access: group 0 device, group 1 power questionable
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        group;
        reg_sel_t    sel;
        logic [15:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] rdata;
    } host_rsp_t;

endpackage

// ==== hdl/sensor_status_register_group.sv ====
`timescale 1ns/1ps
// Summary of operation
// - device condition bit 1 is high while a sensor is attached
// - device condition bit 3 is high while the sensor reports an error
// - condition register is read only; writes leave it unchanged
// - device enable mask is read/write and gates events into summary bit
// - masks and filters hold 0..32767; bit 15 never set
// - event register is read only; writes do nothing
// - reading the event register returns it and clears it
// - falling filter bit latches event on a one-to-zero condition change
// - rising filter bit latches event on a zero-to-one condition change
// - power group summary drives questionable bit 3, OR of enabled events
// - power condition: overload bit 1, zero-needed bit 3, invalid bit 5
////////////////////////////////////////////////////////////////////////////////

module status_group_unit
    import status_group_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [REG_W-1:0] cond,
    input  wire logic             wr_en,
    input  wire logic             rd_event,
    input  wire reg_sel_t         sel,
    input  wire logic [REG_W-1:0] wdata,
    output logic      [REG_W-1:0] enable_r,
    output logic      [REG_W-1:0] event_r,
    output logic      [REG_W-1:0] fall_r,
    output logic      [REG_W-1:0] rise_r,
    output logic                  summary
);
    logic [REG_W-1:0] cond_prev_r;
    logic [REG_W-1:0] hit;

    // previous condition for edge detection
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cond_prev_r <= '0;
        end else begin
            cond_prev_r <= cond;
        end
    end

    // filtered transitions
    assign hit = (cond & ~cond_prev_r & rise_r)
               | (~cond & cond_prev_r & fall_r);

    // sticky event bits, a new hit wins over the read clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            event_r <= RST_EVENT;
        end else begin
            event_r <= (rd_event ? '0 : event_r) | hit;
        end
    end

    // writable masks, bit 15 forced low
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            enable_r <= RST_ENABLE;
            fall_r   <= RST_FALL_FILTER;
            rise_r   <= RST_RISE_FILTER;
        end else if (wr_en) begin
            case (sel)
                SEL_ENABLE: enable_r <= wdata & WRITE_LIMIT_MASK;
                SEL_FALL:   fall_r   <= wdata & WRITE_LIMIT_MASK;
                SEL_RISE:   rise_r   <= wdata & WRITE_LIMIT_MASK;
                default:    ;
            endcase
        end
    end

    assign summary = |(event_r & enable_r);

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_rise_latch;
        @(posedge sys_clk) disable iff (!rst_n)
        ($rose(cond[1]) && rise_r[1]) |=> event_r[1];
    endproperty
    a_rise_latch: assert property (p_rise_latch) else $error("rise not latched");

    property p_fall_latch;
        @(posedge sys_clk) disable iff (!rst_n)
        ($fell(cond[3]) && fall_r[3]) |=> event_r[3];
    endproperty
    a_fall_latch: assert property (p_fall_latch) else $error("fall not latched");

    property p_sticky;
        @(posedge sys_clk) disable iff (!rst_n)
        (event_r[1] && !rd_event) |=> event_r[1];
    endproperty
    a_sticky: assert property (p_sticky) else $error("event bit dropped");

    sequence s_read_quiet;
        rd_event && (hit == '0);
    endsequence

    property p_read_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        s_read_quiet |=> (event_r == '0);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");

    property p_no_bit15;
        @(posedge sys_clk) disable iff (!rst_n)
        !enable_r[15] && !fall_r[15] && !rise_r[15];
    endproperty
    a_no_bit15: assert property (p_no_bit15) else $error("bit 15 set in mask");

    property p_event_write;
        @(posedge sys_clk) disable iff (!rst_n)
        (wr_en && sel == SEL_EVENT && !rd_event && hit == '0) |=> $stable(event_r);
    endproperty
    a_event_write: assert property (p_event_write) else $error("write hit event");

    property p_summary;
        @(posedge sys_clk) disable iff (!rst_n)
        (event_r[1] && enable_r[1]) |-> summary;
    endproperty
    a_summary: assert property (p_summary) else $error("summary missing");

    property p_no_summary;
        @(posedge sys_clk) disable iff (!rst_n)
        (enable_r == '0) |-> !summary;
    endproperty
    a_no_summary: assert property (p_no_summary) else $error("summary unmasked");

    property p_enable_write;
        @(posedge sys_clk) disable iff (!rst_n)
        (wr_en && sel == SEL_ENABLE) |=> (enable_r == ($past(wdata) & WRITE_LIMIT_MASK));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable lost");

    property p_fall_write;
        @(posedge sys_clk) disable iff (!rst_n)
        (wr_en && sel == SEL_FALL) |=> (fall_r == ($past(wdata) & WRITE_LIMIT_MASK));
    endproperty
    a_fall_write: assert property (p_fall_write) else $error("fall filter lost");

    property p_rise_write;
        @(posedge sys_clk) disable iff (!rst_n)
        (wr_en && sel == SEL_RISE) |=> (rise_r == ($past(wdata) & WRITE_LIMIT_MASK));
    endproperty
    a_rise_write: assert property (p_rise_write) else $error("rise filter lost");

    // masks only move on a write to their own group
    property p_mask_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !wr_en |=> ($stable(enable_r) && $stable(fall_r) && $stable(rise_r));
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask moved");

    property p_cond_write;
        @(posedge sys_clk) disable iff (!rst_n)
        (wr_en && sel == SEL_CONDITION)
            |=> ($stable(enable_r) && $stable(fall_r) && $stable(rise_r));
    endproperty
    a_cond_write: assert property (p_cond_write) else $error("cond write landed");

    // no event bit appears without a filtered transition
    property p_no_spurious;
        @(posedge sys_clk) disable iff (!rst_n)
        (hit == '0) |=> ((event_r & ~$past(event_r)) == '0);
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("spurious event");

    // reset values seen on the edge after any reset cycle
    property p_reset_state;
        @(posedge sys_clk)
        !rst_n |=> (enable_r == RST_ENABLE && event_r == RST_EVENT
                    && fall_r == RST_FALL_FILTER && rise_r == RST_RISE_FILTER);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset");
endmodule

////////////////////////////////////////////////////////////////////////////////

module sensor_status_register_group
    import status_group_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      rst_n,
    input  wire logic      sensor_present,
    input  wire logic      sensor_error,
    input  wire logic      input_overload,
    input  wire logic      zeroing_required,
    input  wire logic      data_invalid,
    input  wire host_req_t req,
    output host_rsp_t      rsp,
    output logic           device_summary,
    output logic           questionable_power_summary
);
    logic [REG_W-1:0] dev_cond;
    logic [REG_W-1:0] pq_cond;
    logic [REG_W-1:0] en   [2];
    logic [REG_W-1:0] ev   [2];
    logic [REG_W-1:0] fl   [2];
    logic [REG_W-1:0] rs   [2];
    logic [1:0]       sum;
    logic [REG_W-1:0] rd_nxt;
    host_rsp_t        rsp_r;

    // live condition words, bit 15 always zero
    always_comb begin
        dev_cond                  = '0;
        dev_cond[DEV_SENSOR_BIT]  = sensor_present;
        dev_cond[DEV_ERROR_BIT]   = sensor_error;
        pq_cond                   = '0;
        pq_cond[PQ_OVERLOAD_BIT]  = input_overload;
        pq_cond[PQ_ZERO_REQ_BIT]  = zeroing_required;
        pq_cond[PQ_INVALID_BIT]   = data_invalid;
    end

    // one unit per group
    for (genvar g = 0; g < 2; g++) begin : grp
        status_group_unit u_unit (
            .sys_clk  (sys_clk),
            .rst_n    (rst_n),
            .cond     (g == 0 ? dev_cond : pq_cond),
            .wr_en    (req.valid && req.write && req.group == 1'(g)),
            .rd_event (req.valid && !req.write && req.group == 1'(g)
                       && req.sel == SEL_EVENT),
            .sel      (req.sel),
            .wdata    (req.wdata),
            .enable_r (en[g]),
            .event_r  (ev[g]),
            .fall_r   (fl[g]),
            .rise_r   (rs[g]),
            .summary  (sum[g])
        );
    end

    // read mux
    always_comb begin
        case (req.sel)
            SEL_CONDITION: rd_nxt = req.group ? pq_cond : dev_cond;
            SEL_ENABLE:    rd_nxt = en[req.group];
            SEL_EVENT:     rd_nxt = ev[req.group];
            SEL_FALL:      rd_nxt = fl[req.group];
            SEL_RISE:      rd_nxt = rs[req.group];
            default:       rd_nxt = '0;
        endcase
    end

    // registered answer one cycle after a read
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= req.valid && !req.write;
            rsp_r.rdata <= (req.valid && !req.write) ? rd_nxt : rsp_r.rdata;
        end
    end

    assign rsp                        = rsp_r;
    assign device_summary             = sum[0];
    assign questionable_power_summary = sum[1];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_read_taken;
        req.valid && !req.write;
    endsequence

    sequence s_write_taken;
        req.valid && req.write;
    endsequence

    property p_read_answer;
        @(posedge sys_clk) disable iff (!rst_n)
        s_read_taken |=> rsp.valid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("no read answer");

    property p_write_silent;
        @(posedge sys_clk) disable iff (!rst_n)
        s_write_taken |=> !rsp.valid;
    endproperty
    a_write_silent: assert property (p_write_silent) else $error("write answered");

    // answer data holds while the port is idle
    property p_idle_silent;
        @(posedge sys_clk) disable iff (!rst_n)
        !req.valid |=> (!rsp.valid && $stable(rsp.rdata));
    endproperty
    a_idle_silent: assert property (p_idle_silent) else $error("idle answer");

    property p_dev_cond_read;
        @(posedge sys_clk) disable iff (!rst_n)
        s_read_taken ##0 (req.sel == SEL_CONDITION && !req.group)
            |=> (rsp.rdata == $past(dev_cond));
    endproperty
    a_dev_cond_read: assert property (p_dev_cond_read) else $error("bad cond read");

    property p_pq_cond_read;
        @(posedge sys_clk) disable iff (!rst_n)
        s_read_taken ##0 (req.sel == SEL_CONDITION && req.group)
            |=> (rsp.rdata == $past(pq_cond));
    endproperty
    a_pq_cond_read: assert property (p_pq_cond_read) else $error("bad cond read");

    property p_event_read;
        @(posedge sys_clk) disable iff (!rst_n)
        s_read_taken ##0 (req.sel == SEL_EVENT && !req.group)
            |=> (rsp.rdata == $past(ev[0]));
    endproperty
    a_event_read: assert property (p_event_read) else $error("bad event read");

    property p_bit15_read;
        @(posedge sys_clk) disable iff (!rst_n)
        rsp.valid |-> !rsp.rdata[15];
    endproperty
    a_bit15_read: assert property (p_bit15_read) else $error("bit 15 read high");
endmodule

// ==== testbench/sensor_status_register_group_tb_top.sv ====
`timescale 1ns/1ps
module sensor_status_register_group_tb_top;
    import status_group_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        sp = 1'b0, se = 1'b0, ov = 1'b0, zr = 1'b0, di = 1'b0;
    host_req_t   req = '0;
    host_rsp_t   rsp;
    logic        dsum;
    logic        qsum;
    logic [15:0] rd;
    int          n_fail = 0;
    int          samples_checked = 0;
    sensor_status_register_group dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .sensor_present(sp), .sensor_error(se), .input_overload(ov),
        .zeroing_required(zr), .data_invalid(di), .req(req), .rsp(rsp),
        .device_summary(dsum), .questionable_power_summary(qsum));
    // free-running clock
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic wrap_up;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // compare one word
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // compare a summary flag one cycle on
    task automatic chks(input logic g, input logic e);
        @(posedge sys_clk);
        #1;
        chk({15'h0, g ? qsum : dsum}, {15'h0, e});
    endtask
    // one host access, reads wait for the answer
    task automatic acc(input logic w, input logic g, input reg_sel_t s,
                       input logic [15:0] d);
        int i;
        i = 0;
        @(posedge sys_clk);
        req <= '{valid: 1'b1, write: w, group: g, sel: s, wdata: d};
        @(posedge sys_clk);
        req.valid <= 1'b0;
        if (!w) begin
            #1;  // answer stands only until the next edge
            while (rsp.valid !== 1'b1 && i < 4) begin
                @(posedge sys_clk);
                #1;
                i++;
            end
            if (rsp.valid !== 1'b1) begin
                n_fail++;
                wrap_up();
            end
            rd = rsp.rdata;
        end
    endtask
    // read and compare
    task automatic rchk(input logic g, input reg_sel_t s, input logic [15:0] e);
        acc(1'b0, g, s, 16'h0000);
        chk(rd, e);
    endtask
    // drive conditions present, error, overload, zeroing, invalid
    task automatic setc(input logic [4:0] v);
        @(posedge sys_clk);
        {sp, se, ov, zr, di} <= v;
        repeat (2) @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // reset values of both groups
    task automatic t_reset;
        for (int g = 0; g < 2; g++) begin
            rchk(g[0], SEL_ENABLE, 16'h0000);
            rchk(g[0], SEL_EVENT, 16'h0000);
            rchk(g[0], SEL_FALL, 16'h0000);
            rchk(g[0], SEL_RISE, 16'h7fff);
        end
        chks(1'b0, 1'b0);
    endtask
    // condition bits and write refusal
    task automatic t_cond;
        setc(5'b11000);
        rchk(1'b0, SEL_CONDITION, 16'h000a);
        acc(1'b1, 1'b0, SEL_CONDITION, 16'h0000);
        rchk(1'b0, SEL_CONDITION, 16'h000a);
        setc(5'b00111);
        rchk(1'b1, SEL_CONDITION, 16'h002a);
        rchk(1'b0, SEL_CONDITION, 16'h0000);
    endtask
    // sticky events, clear on read, writes ignored
    task automatic t_event;
        rchk(1'b0, SEL_EVENT, 16'h000a);
        rchk(1'b0, SEL_EVENT, 16'h0000);
        acc(1'b1, 1'b1, SEL_EVENT, 16'h0000);
        chks(1'b1, 1'b0);
        rchk(1'b1, SEL_EVENT, 16'h002a);
        rchk(1'b1, SEL_EVENT, 16'h0000);
    endtask
    // falling filter and value limit
    task automatic t_fall;
        acc(1'b1, 1'b0, SEL_FALL, 16'hffff);
        rchk(1'b0, SEL_FALL, 16'h7fff);
        acc(1'b1, 1'b0, SEL_RISE, 16'h0000);
        setc(5'b01000);
        setc(5'b00000);
        rchk(1'b0, SEL_EVENT, 16'h0008);
    endtask
    // enable masks gate the summaries
    task automatic t_sum;
        acc(1'b1, 1'b0, SEL_RISE, 16'h0002);
        setc(5'b10000);
        acc(1'b1, 1'b0, SEL_ENABLE, 16'h0008);
        chks(1'b0, 1'b0);
        acc(1'b1, 1'b0, SEL_ENABLE, 16'h0002);
        chks(1'b0, 1'b1);
        rchk(1'b0, SEL_ENABLE, 16'h0002);
        rchk(1'b0, SEL_EVENT, 16'h0002);
        chks(1'b0, 1'b0);
        setc(5'b00010);
        acc(1'b1, 1'b1, SEL_ENABLE, 16'h0020);
        chks(1'b1, 1'b0);
        acc(1'b1, 1'b1, SEL_ENABLE, 16'h0008);
        chks(1'b1, 1'b1);
    endtask
    // mid-run reset restores the device group
    task automatic t_rerst;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rchk(1'b0, SEL_ENABLE, 16'h0000);
        rchk(1'b0, SEL_EVENT, 16'h0000);
        rchk(1'b0, SEL_FALL, 16'h0000);
        rchk(1'b0, SEL_RISE, 16'h7fff);
        chks(1'b0, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_cond();
        t_event();
        t_fall();
        t_sum();
        t_rerst();
        wrap_up();
    end
endmodule
